// ===== include/rfs_map.vh
`ifndef RFS_MAP_VH
`define RFS_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// clock and debounce times
`define RFS_CLK_MHZ 50
`define RFS_T_FILT_NS 20000
`define RFS_T_PGOK_NS 8000
`define RFS_T_PGBAD_NS 7000
`define RFS_T_OVL_NS 1000000
`define RFS_CYC(ns) ((((ns) * `RFS_CLK_MHZ) + 999) / 1000)
`define RFS_FILT_CYC `RFS_CYC(`RFS_T_FILT_NS)
`define RFS_PGOK_CYC `RFS_CYC(`RFS_T_PGOK_NS)
`define RFS_PGBAD_CYC `RFS_CYC(`RFS_T_PGBAD_NS)
`define RFS_OVL_CYC `RFS_CYC(`RFS_T_OVL_NS)
`define RFS_IMMEDIATE_CYC 1

////////////////////////////////////////////////////////////////////////////////
// device modes
`define RFS_DEV_SHUTDOWN 2'h0
`define RFS_DEV_STANDBY 2'h1
`define RFS_DEV_ACTIVE 2'h2

////////////////////////////////////////////////////////////////////////////////
// regulator sequencing states
`define RFS_REG_OFF 2'h0
`define RFS_REG_START 2'h1
`define RFS_REG_ON 2'h2
`define RFS_REG_STOP 2'h3

////////////////////////////////////////////////////////////////////////////////
// power-good source select field
`define RFS_PGSEL_NONE 2'h0
`define RFS_PGSEL_VOLT 2'h1
`define RFS_PGSEL_CUR_BIT 1

`endif

// ===== sim/rfs_checker.sv
`include "rfs_map.vh"
////////////////////////////////////////////////////////////////////////////////
module rfs_checker #(
	parameter N = 4,
	parameter OVERLOAD_CYCLES = `RFS_OVL_CYC
) (
	// clock and reset
	input wire core_clk,
	input wire resetn,
	// configuration
	input wire [2*N-1:0] pgSourceSelect,
	input wire [N-1:0] outputDischargeEnable,
	// regulator status
	input wire [N-1:0] powerStageEnable,
	input wire [N-1:0] outputDischargeOn,
	input wire [N-1:0] currentLimitFlag,
	input wire [N-1:0] shortCircuitFlag,
	input wire [N-1:0] regulatorSummaryFlag,
	input wire [N-1:0] pgInput,
	// device status
	input wire powerGoodOutput,
	input wire thermalWarnFlag,
	input wire thermalShutdownFlag,
	input wire thermalShutdownLiveStatus,
	input wire inputOvervoltageFlag,
	input wire inputOvervoltageLiveStatus,
	input wire resetOccurredFlag,
	input wire gpioForceLow,
	input wire interruptRequestN,
	input wire [1:0] deviceMode
);
	timeunit 1ns;
	timeprecision 1ps;
	wire allPg = &pgInput;
	wire hardFlag = inputOvervoltageFlag | thermalShutdownFlag;
	// the summary flag only mirrors the others, so it stays out of the line
	wire anyFlag = |{currentLimitFlag, shortCircuitFlag, thermalWarnFlag, hardFlag,
		resetOccurredFlag};
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	chk_pg_unmon: assert property (pgSourceSelect[3:2] == `RFS_PGSEL_NONE |=> pgInput[1])
		else $error("unmonitored input inactive");
	chk_pg_and: assert property (1'h1 |=> powerGoodOutput == $past(allPg))
		else $error("combined power-good wrong");
	chk_irq_any: assert property (1'h1 |=> interruptRequestN == !$past(anyFlag))
		else $error("interrupt line wrong");
	chk_gpio_low: assert property (1'h1 |=> gpioForceLow == $past(hardFlag))
		else $error("gpio force wrong");
	chk_sc_kill:
		assert property ($rose(shortCircuitFlag[0]) |-> !powerStageEnable[0] && regulatorSummaryFlag[0])
		else $error("short flag without disable");
	chk_ovp_kill:
		assert property (inputOvervoltageLiveStatus |=> !powerStageEnable && inputOvervoltageFlag)
		else $error("overvoltage did not disable");
	chk_tsd_kill:
		assert property (thermalShutdownLiveStatus |=> !powerStageEnable && thermalShutdownFlag)
		else $error("overheat did not disable");
	chk_dis_gate:
		assert property ((outputDischargeOn & ~outputDischargeEnable) != 0 |->
			deviceMode == `RFS_DEV_SHUTDOWN)
		else $error("discharge without enable");

	cover property ($rose(shortCircuitFlag[0]));
	cover property ($rose(inputOvervoltageFlag));
	cover property ($rose(powerGoodOutput));
endmodule

// ===== sim/rfs_host_model.sv
////////////////////////////////////////////////////////////////////////////////
// host side: answers a low interrupt line by writing ones to every flag
module rfs_host_model #(
	parameter N = 4
) (
	// clock and service enable
	input wire core_clk,
	input wire svcEn,
	// interrupt line
	input wire interruptRequestN,
	// write-one-to-clear strobes
	output wire [N-1:0] clrCurrentLimit,
	output wire [N-1:0] clrShortCircuit,
	output wire [N-1:0] clrRegSummary,
	output wire clrThermalWarn,
	output wire clrThermalShutdown,
	output wire clrOvervoltage,
	output wire clrResetOccurred
);
	timeunit 1ns;
	timeprecision 1ps;
	// every phase of one rail gets this one peak current setting; the block has no port for it
	localparam logic [2:0] PEAK_LIMIT_ALL = 3'h5;
	logic [3*N+3:0] clrAll = '0;
	assign {clrCurrentLimit, clrShortCircuit, clrRegSummary, clrThermalWarn,
		clrThermalShutdown, clrOvervoltage, clrResetOccurred} = clrAll;
	// a slow host leaves the line low for up to eight cycles before writing
	initial forever begin
		@(posedge core_clk);
		#2;
		if (svcEn && interruptRequestN === 1'h0) begin
			repeat ($urandom_range(8, 0)) @(posedge core_clk);
			#2;
			clrAll = '1;
			@(posedge core_clk);
			#2;
			clrAll = '0;
		end
	end
endmodule

// ===== sim/tb.sv
`include "rfs_map.vh"
////////////////////////////////////////////////////////////////////////////////
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int N = 4;
	localparam int OVL = 64;
	logic core_clk, resetn, analogSupplyOk, analogSupplyOver, chipResetInN, softResetReq;
	logic tempAboveWarnLow, tempAboveWarnHigh, tempAboveShutdown, thermalWarnThresholdSelect;
	logic pgWindowSelect, resetOccurredMask, svcEn;
	logic [N-1:0] currentLimitActive, feedbackBelowShort, outputAboveUv, outputBelowOv;
	logic [N-1:0] rampBusy, stopBusy, regEnable, outputDischargeEnable;
	logic [2*N-1:0] pgSourceSelect;
	wire [N-1:0] clrCurrentLimit, clrShortCircuit, clrRegSummary, powerStageEnable;
	wire [N-1:0] outputDischargeOn, regulatorRunningStatus, currentLimitLiveStatus;
	wire [N-1:0] currentLimitFlag, shortCircuitFlag, regulatorSummaryFlag, pgInput;
	wire clrThermalWarn, clrThermalShutdown, clrOvervoltage, clrResetOccurred;
	wire powerGoodOutput, thermalWarnFlag, thermalWarnLiveStatus, thermalShutdownFlag;
	wire thermalShutdownLiveStatus, inputOvervoltageFlag, inputOvervoltageLiveStatus;
	wire resetOccurredFlag, gpioForceLow, interruptRequestN;
	wire [1:0] deviceMode;
	int bad_count, tests_run, i;

	rfs_supervisor #(.N(N), .OVERLOAD_CYCLES(OVL)) u_rfs_supervisor (.*);
	rfs_host_model #(.N(N)) u_rfs_host_model (.*);

	initial begin
		core_clk = 1'h0;
		forever #10 core_clk = ~core_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#2;
	endtask

	task automatic check(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'h1) begin
			bad_count++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// expected warning level for the chosen threshold
	function automatic logic warnLevel(input logic sel, input logic hi, input logic lo);
		return sel ? hi : lo;
	endfunction

	function automatic logic probe(input int k);
		case (k)
			0: return deviceMode === `RFS_DEV_STANDBY;
			1: return pgInput[0];
			2: return currentLimitLiveStatus[0];
			3: return shortCircuitFlag[0];
			4: return powerStageEnable[0];
			5: return inputOvervoltageFlag;
			6: return !inputOvervoltageFlag;
			7: return thermalShutdownFlag;
			8: return thermalWarnFlag;
			9: return !pgInput[0];
			default: return !thermalShutdownFlag;
		endcase
	endfunction

	task automatic waitFor(input int k, input int lim);
		int n;
		n = 0;
		while (probe(k) !== 1'h1) begin
			if (n == lim) begin
				bad_count++;
				$display("[FAIL] %0t wait %0d timed out", $time, k);
				end_of_test();
			end
			step(1);
			n++;
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(71008));
		{resetn, analogSupplyOver, softResetReq, svcEn, resetOccurredMask} = 5'h00;
		{analogSupplyOk, chipResetInN, pgWindowSelect} = 3'h7;
		{tempAboveWarnLow, tempAboveWarnHigh, tempAboveShutdown} = 3'h0;
		thermalWarnThresholdSelect = 1'h0;
		{currentLimitActive, feedbackBelowShort, rampBusy, stopBusy, regEnable} = '0;
		{outputAboveUv, outputBelowOv} = '1;
		outputDischargeEnable = N'($urandom);
		pgSourceSelect = 8'h01;
		step(6);
		resetn = 1'h1;
		waitFor(0, 1100);
		check(resetOccurredFlag, "reset flag");
		step(2);
		check(!interruptRequestN, "no power-up irq");
		svcEn = 1'h1;
		step(15);
		check(!resetOccurredFlag && interruptRequestN, "reset flag stuck");
		svcEn = 1'h0;
		$display("power-up test done");

		regEnable = 4'h3;
		rampBusy[0] = 1'h1;
		step(3);
		check(powerStageEnable[0] && !pgInput[0] && pgInput[1], "start pg");
		check(deviceMode === `RFS_DEV_ACTIVE && !powerGoodOutput, "active");
		step(20);
		rampBusy[0] = 1'h0;
		step(395);
		check(!pgInput[0], "pg before filter");
		waitFor(1, 20);
		step(2);
		check(powerGoodOutput, "combined pg");
		// any dip shorter than the invalid filter must pass unseen
		outputAboveUv[0] = 1'h0;
		step($urandom_range(340, 1));
		outputAboveUv[0] = 1'h1;
		step(5);
		check(pgInput[0], "dip dropped pg");
		pgWindowSelect = 1'h0;
		outputBelowOv[0] = 1'h0;
		step(400);
		check(pgInput[0], "ov in uv-only mode");
		pgWindowSelect = 1'h1;
		waitFor(9, 370);
		outputBelowOv[0] = 1'h1;
		waitFor(1, 420);
		rampBusy[0] = 1'h1;
		step(3);
		check(!pgInput[0] && powerStageEnable[0], "pg in voltage ramp");
		rampBusy[0] = 1'h0;
		waitFor(1, 420);
		regEnable[0] = 1'h0;
		stopBusy[0] = 1'h1;
		step(5);
		check(powerStageEnable[0] && pgInput[0], "pg in ramp-down");
		stopBusy[0] = 1'h0;
		step(3);
		check(!powerStageEnable[0] && pgInput[0], "not off");
		$display("power-good test done");

		regEnable[0] = 1'h1;
		waitFor(9, 5);
		waitFor(1, 420);
		pgSourceSelect[1:0] = 2'h2;
		currentLimitActive[0] = 1'h1;
		step(990);
		check(!currentLimitLiveStatus[0] && !currentLimitFlag[0], "limit early");
		waitFor(2, 20);
		step(2);
		check(currentLimitFlag[0] && regulatorSummaryFlag[0] && !pgInput[0], "limit");
		step(1);
		check(!interruptRequestN, "no limit irq");
		svcEn = 1'h1;
		step(15);
		check(currentLimitFlag[0], "limit flag cleared while live");
		currentLimitActive[0] = 1'h0;
		step(1030);
		check(!currentLimitFlag[0] && interruptRequestN && pgInput[0], "limit end");
		svcEn = 1'h0;
		pgSourceSelect[1:0] = 2'h1;
		$display("current-limit test done");

		feedbackBelowShort[0] = 1'h1;
		step(OVL);
		check(!shortCircuitFlag[0], "overload early");
		waitFor(3, 10);
		check(!powerStageEnable[0] && !regulatorRunningStatus[0], "not disabled");
		check(outputDischargeOn[0] === outputDischargeEnable[0], "discharge");
		step(2);
		check(!pgInput[0] && !interruptRequestN, "overload pg/irq");
		svcEn = 1'h1;
		waitFor(4, 20);
		svcEn = 1'h0;
		waitFor(3, 80);
		feedbackBelowShort[0] = 1'h0;
		svcEn = 1'h1;
		waitFor(4, 20);
		step(12);
		svcEn = 1'h0;
		$display("overload test done");

		analogSupplyOver = 1'h1;
		waitFor(5, 1010);
		step(3);
		check(powerStageEnable === 4'h0 && regulatorRunningStatus === 4'h0, "ovp");
		check(gpioForceLow && !interruptRequestN && !pgInput[0], "ovp outputs");
		svcEn = 1'h1;
		step(20);
		check(inputOvervoltageFlag && !powerStageEnable[0], "ovp cleared");
		analogSupplyOver = 1'h0;
		waitFor(6, 1030);
		waitFor(4, 10);
		svcEn = 1'h0;
		$display("overvoltage test done");

		tempAboveShutdown = 1'h1;
		waitFor(7, 1010);
		step(3);
		check(powerStageEnable === 4'h0 && deviceMode === `RFS_DEV_STANDBY, "tsd");
		check(!pgInput[0] && gpioForceLow, "tsd outputs");
		svcEn = 1'h1;
		step(20);
		check(thermalShutdownFlag, "tsd cleared hot");
		tempAboveShutdown = 1'h0;
		waitFor(10, 1030);
		waitFor(4, 10);
		svcEn = 1'h0;
		$display("thermal shutdown test done");

		for (i = 0; i < 2; i++) begin
			thermalWarnThresholdSelect = i[0];
			{tempAboveWarnHigh, tempAboveWarnLow} = i[0] ? 2'h2 : 2'h1;
			waitFor(8, 1010);
			step(2);
			check(thermalWarnLiveStatus === warnLevel(i[0], tempAboveWarnHigh, tempAboveWarnLow)
				&& !interruptRequestN, "warn");
			// only the unselected comparator is high now
			{tempAboveWarnHigh, tempAboveWarnLow} = i[0] ? 2'h1 : 2'h2;
			svcEn = 1'h1;
			step(1030);
			check(!thermalWarnFlag && interruptRequestN, "warn stuck");
			svcEn = 1'h0;
		end
		$display("thermal warning test done");

		analogSupplyOk = 1'h0;
		step(5);
		check(deviceMode === `RFS_DEV_SHUTDOWN && powerStageEnable === 4'h0, "uvlo");
		check(outputDischargeOn === 4'hF, "uvlo discharge");
		analogSupplyOk = 1'h1;
		waitFor(0, 1100);
		check(resetOccurredFlag, "reset flag after uvlo");
		regEnable = '0;
		svcEn = 1'h1;
		step(15);
		svcEn = 1'h0;
		resetOccurredMask = 1'h1;
		softResetReq = 1'h1;
		step(2);
		check(deviceMode === `RFS_DEV_SHUTDOWN, "soft reset");
		softResetReq = 1'h0;
		waitFor(0, 5);
		check(!resetOccurredFlag, "masked reset flag");
		chipResetInN = 1'h0;
		step(4);
		check(deviceMode === `RFS_DEV_SHUTDOWN && outputDischargeOn === 4'hF, "reset pin");
		resetOccurredMask = 1'h0;
		chipResetInN = 1'h1;
		waitFor(0, 10);
		check(resetOccurredFlag, "reset flag after pin");
		$display("undervoltage test done");
		end_of_test();
	end
endmodule

bind rfs_supervisor rfs_checker #(.N(N), .OVERLOAD_CYCLES(OVERLOAD_CYCLES)) u_rfs_checker (.*);

// ===== verilog/rfs_debounce.v
// output follows the input only after the input has differed from it for
// the rise or fall count of consecutive cycles; clr forces low immediately
module rfs_debounce #(
	parameter CW = 17,
	parameter RISE = 1000,
	parameter FALL = 1000
) (
	// clock and reset
	input wire core_clk,
	input wire resetn,
	// condition
	input wire rawIn,
	input wire clr,
	output reg filtOut
);

	// counts are cut to the counter width on purpose; a count above 2**CW would wrap
	localparam [31:0] RISE_END = RISE - 1;
	localparam [31:0] FALL_END = FALL - 1;
	localparam [CW-1:0] RISE_LAST = RISE_END[CW-1:0];
	localparam [CW-1:0] FALL_LAST = FALL_END[CW-1:0];

	reg [CW-1:0] cnt_reg;

	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_reg <= {CW{1'b0}};
			filtOut <= 1'b0;
		end else if (clr) begin
			cnt_reg <= {CW{1'b0}};
			filtOut <= 1'b0;
		end else if (rawIn == filtOut) begin
			cnt_reg <= {CW{1'b0}};
		end else if (cnt_reg == (rawIn ? RISE_LAST : FALL_LAST)) begin
			cnt_reg <= {CW{1'b0}};
			filtOut <= rawIn;
		end else begin
			cnt_reg <= cnt_reg + {{(CW-1){1'b0}}, 1'b1};
		end
	end

endmodule

// ===== verilog/rfs_supervisor.v
// Contract
// - unmonitored (select 00) or disabled regulator gives active power-good input.
// - monitored input inactive through start-up, active after debounced in-window time.
// - debounced current limit drops input only when current monitoring is selected.
// - debounced excursion outside the voltage window drops the input.
// - voltage change ramp drops input until window holds past debounce again.
// - shutdown delay and ramp-down keep the input active.
// - regulator killed by thermal, overvoltage or short keeps input inactive while pending.
// - 20 us continuous peak current regulation sets limit flag and interrupt.
// - live current-limit status is readable beside the sticky flag.
// - output under 350 mV 1 ms after enable disables regulator as short.
// - feedback under 0.35 V for 1 ms in operation disables as overload.
// - short or overload sets short flag, summary flag, clears running, interrupts.
// - host clears short flag by writing 1; enabled regulator then restarts.
// - thermal warning at selected level sets flag, interrupt, live status; write 1 clears.
// - fault disable floats power stage; discharge only when its enable bit is set.
// - overvoltage disables all, forces GPIO low, flag, interrupt, clears running bits.
// - overvoltage flag holds while active; enabling blocked while live or pending.
// - thermal shutdown disables all, sets flag, interrupts, goes to STANDBY.
// - thermal shutdown flag clears only when cool; enabling blocked meanwhile.
// - undervoltage lockout disables and discharges, SHUTDOWN; STANDBY when supply and reset ok.
// - reset-occurred flag set after SHUTDOWN unless masked; host clears by writing 1.
// - combined power-good active only when every regulator input is active.
// - window select 0 checks undervoltage only, 1 checks both limits.
`include "rfs_map.vh"

module rfs_supervisor #(
	parameter N = 4,
	parameter OVERLOAD_CYCLES = `RFS_OVL_CYC
) (
	// clock and reset
	input wire core_clk,
	input wire resetn,
	// supply, reset pin and software reset
	input wire analogSupplyOk,
	input wire analogSupplyOver,
	input wire chipResetInN,
	input wire softResetReq,
	// die temperature comparators
	input wire tempAboveWarnLow,
	input wire tempAboveWarnHigh,
	input wire tempAboveShutdown,
	input wire thermalWarnThresholdSelect,
	// per regulator comparators
	input wire [N-1:0] currentLimitActive,
	input wire [N-1:0] feedbackBelowShort,
	input wire [N-1:0] outputAboveUv,
	input wire [N-1:0] outputBelowOv,
	// per regulator converter sequencing
	input wire [N-1:0] rampBusy,
	input wire [N-1:0] stopBusy,
	// configuration
	input wire [N-1:0] regEnable,
	input wire [2*N-1:0] pgSourceSelect,
	input wire pgWindowSelect,
	input wire [N-1:0] outputDischargeEnable,
	input wire resetOccurredMask,
	// write-one-to-clear strobes
	input wire [N-1:0] clrCurrentLimit,
	input wire [N-1:0] clrShortCircuit,
	input wire [N-1:0] clrRegSummary,
	input wire clrThermalWarn,
	input wire clrThermalShutdown,
	input wire clrOvervoltage,
	input wire clrResetOccurred,
	// regulator control
	output wire [N-1:0] powerStageEnable,
	output wire [N-1:0] outputDischargeOn,
	output wire [N-1:0] regulatorRunningStatus,
	// per regulator status
	output wire [N-1:0] currentLimitLiveStatus,
	output wire [N-1:0] currentLimitFlag,
	output wire [N-1:0] shortCircuitFlag,
	output wire [N-1:0] regulatorSummaryFlag,
	output wire [N-1:0] pgInput,
	// device status
	output reg powerGoodOutput,
	output reg thermalWarnFlag,
	output wire thermalWarnLiveStatus,
	output reg thermalShutdownFlag,
	output wire thermalShutdownLiveStatus,
	output reg inputOvervoltageFlag,
	output wire inputOvervoltageLiveStatus,
	output reg resetOccurredFlag,
	output reg gpioForceLow,
	output reg interruptRequestN,
	output wire [1:0] deviceMode
);

	localparam SW = 4 * N + 6;

	////////////////////////////////////////////////////////////////////////////
	// two-flop synchronisers for every comparator and pin

	wire [SW-1:0] pinRaw;
	reg [SW-1:0] syncA_reg;
	reg [SW-1:0] syncB_reg;

	assign pinRaw = {tempAboveShutdown, tempAboveWarnHigh, tempAboveWarnLow,
		chipResetInN, analogSupplyOver, analogSupplyOk,
		outputBelowOv, outputAboveUv, feedbackBelowShort, currentLimitActive};

	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			syncA_reg <= {SW{1'b0}};
			syncB_reg <= {SW{1'b0}};
		end else begin
			syncA_reg <= pinRaw;
			syncB_reg <= syncA_reg;
		end
	end

	wire [N-1:0] ilimS = syncB_reg[N-1:0];
	wire [N-1:0] fbLowS = syncB_reg[2*N-1:N];
	wire [N-1:0] uvOkS = syncB_reg[3*N-1:2*N];
	wire [N-1:0] ovOkS = syncB_reg[4*N-1:3*N];
	wire supOkS = syncB_reg[4*N];
	wire ovpS = syncB_reg[4*N+1];
	wire nrstS = syncB_reg[4*N+2];
	wire warnLoS = syncB_reg[4*N+3];
	wire warnHiS = syncB_reg[4*N+4];
	wire tsdS = syncB_reg[4*N+5];

	////////////////////////////////////////////////////////////////////////////
	// device-level filters

	reg [1:0] devState_reg;
	reg [1:0] devState_next;
	wire devShut = (devState_reg == `RFS_DEV_SHUTDOWN);
	wire supFilt;
	wire warnRaw = thermalWarnThresholdSelect ? warnHiS : warnLoS;

	// rising supply is filtered, a falling one acts at once
	rfs_debounce #(.RISE(`RFS_FILT_CYC), .FALL(`RFS_IMMEDIATE_CYC)) u_supply (
		.core_clk(core_clk),
		.resetn(resetn),
		.rawIn(supOkS),
		.clr(1'b0),
		.filtOut(supFilt)
	);

	// overvoltage is only watched in standby and active
	rfs_debounce #(.RISE(`RFS_FILT_CYC), .FALL(`RFS_FILT_CYC)) u_ovp (
		.core_clk(core_clk),
		.resetn(resetn),
		.rawIn(ovpS),
		.clr(devShut),
		.filtOut(inputOvervoltageLiveStatus)
	);

	rfs_debounce #(.RISE(`RFS_FILT_CYC), .FALL(`RFS_FILT_CYC)) u_warn (
		.core_clk(core_clk),
		.resetn(resetn),
		.rawIn(warnRaw),
		.clr(devShut),
		.filtOut(thermalWarnLiveStatus)
	);

	rfs_debounce #(.RISE(`RFS_FILT_CYC), .FALL(`RFS_FILT_CYC)) u_tsd (
		.core_clk(core_clk),
		.resetn(resetn),
		.rawIn(tsdS),
		.clr(devShut),
		.filtOut(thermalShutdownLiveStatus)
	);

	wire supplyOk = supFilt & supOkS;
	wire devShutReq = ~supplyOk | ~nrstS | softResetReq;
	wire ovpLive = inputOvervoltageLiveStatus;
	wire tsdLive = thermalShutdownLiveStatus;
	wire [N-1:0] regOn;

	////////////////////////////////////////////////////////////////////////////
	// device mode machine

	always @* begin
		devState_next = devState_reg;
		case (devState_reg)
			`RFS_DEV_SHUTDOWN: begin
				if (!devShutReq)
					devState_next = `RFS_DEV_STANDBY;
			end
			`RFS_DEV_STANDBY: begin
				if (devShutReq)
					devState_next = `RFS_DEV_SHUTDOWN;
				else if (|regOn)
					devState_next = `RFS_DEV_ACTIVE;
			end
			`RFS_DEV_ACTIVE: begin
				if (devShutReq)
					devState_next = `RFS_DEV_SHUTDOWN;
				else if (~|regOn)
					devState_next = `RFS_DEV_STANDBY;
			end
			default: begin
				devState_next = `RFS_DEV_SHUTDOWN;
			end
		endcase
	end

	assign deviceMode = devState_reg;

	wire resetSet = devShut & ~devShutReq & ~resetOccurredMask;

	// the live level re-sets each flag every cycle, so a write of one cannot
	// clear it while the condition lasts; in shutdown all but the reset flag return to default
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			devState_reg <= `RFS_DEV_SHUTDOWN;
			inputOvervoltageFlag <= 1'b0;
			thermalShutdownFlag <= 1'b0;
			thermalWarnFlag <= 1'b0;
			resetOccurredFlag <= 1'b0;
		end else begin
			devState_reg <= devState_next;
			resetOccurredFlag <= resetSet | (resetOccurredFlag & ~clrResetOccurred);
			if (devShut) begin
				inputOvervoltageFlag <= 1'b0;
				thermalShutdownFlag <= 1'b0;
				thermalWarnFlag <= 1'b0;
			end else begin
				inputOvervoltageFlag <= ovpLive | (inputOvervoltageFlag & ~clrOvervoltage);
				thermalShutdownFlag <= tsdLive | (thermalShutdownFlag & ~clrThermalShutdown);
				thermalWarnFlag <= thermalWarnLiveStatus | (thermalWarnFlag & ~clrThermalWarn);
			end
		end
	end

	wire globalBlock = ovpLive | inputOvervoltageFlag | tsdLive | thermalShutdownFlag | devShut;
	wire globalKill = ovpLive | tsdLive | devShut;

	////////////////////////////////////////////////////////////////////////////
	// per regulator sequencing, protection and power-good

	genvar i;
	generate
		for (i = 0; i < N; i = i + 1) begin : g_reg
			reg [1:0] st_reg;
			reg [1:0] st_next;
			reg faultOff_reg;
			reg ilimFlag_reg;
			reg scFlag_reg;
			reg sumFlag_reg;
			reg pg_reg;
			reg pg_next;
			wire ilimLive;
			wire ovlTrip;
			wire winOk;
			wire [1:0] sel = pgSourceSelect[2*i+1:2*i];
			wire winRaw = uvOkS[i] & (pgWindowSelect ? ovOkS[i] : 1'b1);
			wire block = globalBlock | scFlag_reg;
			wire kill = globalKill | ovlTrip;
			wire ilimRise = ilimLive & ~ilimFlag_reg;

			rfs_debounce #(.RISE(`RFS_FILT_CYC), .FALL(`RFS_FILT_CYC)) u_ilim (
				.core_clk(core_clk),
				.resetn(resetn),
				.rawIn(ilimS[i]),
				.clr(devShut),
				.filtOut(ilimLive)
			);

			// one timer covers the start-up check and the running overload:
			// feedback held low for the whole interval since enable or since dip
			rfs_debounce #(.RISE(OVERLOAD_CYCLES), .FALL(`RFS_FILT_CYC)) u_ovl (
				.core_clk(core_clk),
				.resetn(resetn),
				.rawIn(fbLowS[i]),
				.clr(st_reg == `RFS_REG_OFF),
				.filtOut(ovlTrip)
			);

			// cleared outside steady operation so each ramp needs a fresh window
			rfs_debounce #(.RISE(`RFS_PGOK_CYC), .FALL(`RFS_PGBAD_CYC)) u_win (
				.core_clk(core_clk),
				.resetn(resetn),
				.rawIn(winRaw),
				.clr(st_reg != `RFS_REG_ON),
				.filtOut(winOk)
			);

			always @* begin
				st_next = st_reg;
				case (st_reg)
					`RFS_REG_OFF: begin
						if (regEnable[i] & ~block)
							st_next = `RFS_REG_START;
					end
					`RFS_REG_START: begin
						if (kill)
							st_next = `RFS_REG_OFF;
						else if (!rampBusy[i])
							st_next = `RFS_REG_ON;
					end
					`RFS_REG_ON: begin
						if (kill)
							st_next = `RFS_REG_OFF;
						else if (!regEnable[i])
							st_next = `RFS_REG_STOP;
						else if (rampBusy[i])
							st_next = `RFS_REG_START;
					end
					default: begin
						if (kill)
							st_next = `RFS_REG_OFF;
						else if (regEnable[i])
							st_next = `RFS_REG_START;
						else if (!stopBusy[i])
							st_next = `RFS_REG_OFF;
					end
				endcase
			end

			always @* begin
				pg_next = 1'b1;
				if (sel == `RFS_PGSEL_NONE)
					pg_next = 1'b1;
				else if (faultOff_reg & (scFlag_reg | inputOvervoltageFlag | thermalShutdownFlag))
					pg_next = 1'b0;
				else begin
					case (st_reg)
						`RFS_REG_OFF: pg_next = 1'b1;
						`RFS_REG_START: pg_next = 1'b0;
						`RFS_REG_ON: pg_next = winOk & ~(sel[`RFS_PGSEL_CUR_BIT] & ilimLive);
						default: pg_next = 1'b1;
					endcase
				end
			end

			always @(posedge core_clk or negedge resetn) begin
				if (!resetn) begin
					st_reg <= `RFS_REG_OFF;
					faultOff_reg <= 1'b0;
					ilimFlag_reg <= 1'b0;
					scFlag_reg <= 1'b0;
					sumFlag_reg <= 1'b0;
					pg_reg <= 1'b1;
				end else begin
					st_reg <= st_next;
					pg_reg <= pg_next;
					if ((st_reg != `RFS_REG_OFF) & kill)
						faultOff_reg <= 1'b1;
					else if (st_next != `RFS_REG_OFF)
						faultOff_reg <= 1'b0;
					if (devShut) begin
						ilimFlag_reg <= 1'b0;
						scFlag_reg <= 1'b0;
						sumFlag_reg <= 1'b0;
					end else begin
						ilimFlag_reg <= ilimLive | (ilimFlag_reg & ~clrCurrentLimit[i]);
						scFlag_reg <= ovlTrip | (scFlag_reg & ~clrShortCircuit[i]);
						sumFlag_reg <= ilimRise | ovlTrip | (sumFlag_reg & ~clrRegSummary[i]);
					end
				end
			end

			assign regOn[i] = (st_reg != `RFS_REG_OFF);
			assign powerStageEnable[i] = regOn[i];
			assign regulatorRunningStatus[i] = regOn[i];
			// lockout discharges regardless of the enable bit
			assign outputDischargeOn[i] = devShut | (faultOff_reg & outputDischargeEnable[i]);
			assign currentLimitLiveStatus[i] = ilimLive;
			assign currentLimitFlag[i] = ilimFlag_reg;
			assign shortCircuitFlag[i] = scFlag_reg;
			assign regulatorSummaryFlag[i] = sumFlag_reg;
			assign pgInput[i] = pg_reg;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// combined outputs

	wire anyFlag = (|currentLimitFlag) | (|shortCircuitFlag) | thermalWarnFlag |
		thermalShutdownFlag | inputOvervoltageFlag | resetOccurredFlag;

	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			powerGoodOutput <= 1'b0;
			interruptRequestN <= 1'b1;
			gpioForceLow <= 1'b0;
		end else begin
			powerGoodOutput <= &pgInput;
			interruptRequestN <= ~anyFlag;
			gpioForceLow <= inputOvervoltageFlag | thermalShutdownFlag;
		end
	end

endmodule
